// ===== bench/mtsr_medium.sv
// medium model driving the line side of the block
module mtsr_medium
  import mtsr_pkg::*;
(
  input wire logic pclk,
  input wire logic tx_abort,
  output mtsr_pkg::mtsr_line_t line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  bit ab;
  initial line_in = '0;
  // ----
  // wait, noting an abort
  // ----
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (tx_abort) ab = 1'b1;
    end
  endtask
  // ----
  // one frame: preamble, delimiter, collisions, end
  // ----
  task automatic send(input int ncoll, input bit crs, input bit late, input bit dfr);
    ab = 1'b0;
    line_in.preamble_start <= 1'b1;
    line_in.deferred <= dfr;
    tick(3);
    line_in.preamble_start <= 1'b0;
    line_in.deferred <= 1'b0;
    line_in.sfd <= 1'b1;
    line_in.carrier_sense <= crs;
    tick(3);
    line_in.sfd <= 1'b0;
    for (int i = 0; i < ncoll && !ab; i++)
    begin
      tick(late ? 1100 : 8);
      line_in.collision <= 1'b1;
      tick(3);
      line_in.collision <= 1'b0;
    end
    tick(40);
    if (!ab)
    begin
      line_in.done <= 1'b1;
      tick(3);
      line_in.done <= 1'b0;
    end
    line_in.carrier_sense <= 1'b0;
  endtask
endmodule // mtsr_medium

// ===== bench/mtsr_properties.sv
// port checker for the mac transmit status block
module mtsr_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_abort,
  input wire logic rx_crc_enable,
  input wire logic desc_write_req,
  input wire logic status_written,
  input wire logic [15:0] tx_descriptor_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [15:0] sw = tx_descriptor_status_word;
  // ----
  // bus handshake
  // ----
  sequence setup_phase;
    psel && !penable;
  endsequence
  chk_ready_wait: assert property (setup_phase |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_unmapped_err: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr)
    else $error("no pslverr");
  // ----
  // status relations, crc enable, descriptor request hold and abort pulse
  // ----
  chk_ok_clean: assert property (
    sw[0] |-> !(sw[1] || sw[2] || sw[6] || sw[10])) else $error("ok with error");
  chk_exc_mismatch: assert property (
    sw[6] |-> sw[1]) else $error("exc without mismatch");
  chk_carrier_pair: assert property (
    sw[8] |-> sw[7]) else $error("no carrier without lost");
  chk_crc_on: assert property (
    $past(presetn) |-> rx_crc_enable) else $error("crc checker off");
  chk_desc_hold: assert property (
    desc_write_req && !status_written |=> desc_write_req) else $error("desc req dropped");
  chk_abort_pulse: assert property (
    tx_abort |=> !tx_abort) else $error("abort held");
endmodule // mtsr_properties

bind mtsr_top mtsr_properties u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .tx_abort, .rx_crc_enable, .desc_write_req, .status_written,
  .tx_descriptor_status_word);

// ===== bench/tb.sv
// self-checking bench for the mac transmit status block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mtsr_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    int ncoll;
    bit crs, late, fu, byte_count_mismatch_flag, al;
    int nab, nrt;
    logic [15:0] exp;
  } mtsr_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, status_written;
  logic tx_abort, backoff_retry, rx_crc_enable, desc_write_req, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tx_descriptor_status_word;
  mtsr_line_t line_in;
  mtsr_dma_t dma_in;
  mtsr_mon_t mon_in;
  int error_cnt, n_checks, nab, nrt, k;
  mtsr_row_t r;
  localparam logic [15:0] MASK = 16'h01EF;
  mtsr_row_t rows [10] = '{
    '{32'h0, 0, 1, 0, 0, 0, 0, 0, 0, 16'h0001},
    '{32'h0, 0, 0, 0, 0, 0, 0, 0, 0, 16'h0181},
    '{32'h0, 16, 1, 0, 0, 0, 0, 1, 15, 16'h0042},
    '{32'h0, 1, 1, 1, 0, 0, 0, 0, 1, 16'h0021},
    '{32'h2, 1, 1, 1, 0, 0, 0, 0, 1, 16'h0021},
    '{32'h0, 0, 1, 0, 1, 0, 0, 1, 0, 16'h0184},
    '{32'h0, 0, 1, 0, 0, 1, 0, 1, 0, 16'h0182},
    '{32'h0, 0, 1, 0, 0, 0, 1, 0, 0, 16'h0009},
    '{32'h1, 0, 1, 0, 0, 0, 1, 0, 0, 16'h0001},
    '{32'h8, 0, 1, 0, 0, 0, 1, 0, 0, 16'h0081}};
  mtsr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .line_in, .dma_in, .mon_in, .status_written, .tx_abort,
    .backoff_retry, .rx_crc_enable, .desc_write_req, .tx_descriptor_status_word, .irq);
  mtsr_medium med (.pclk, .tx_abort, .line_in);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (tx_abort) nab++;
    if (backoff_retry) nrt++;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, status_written} = '0;
    dma_in = '0;
    dma_in.size_valid = 1'b1;
    mon_in = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("crc_enable", 1, rx_crc_enable);
    apb(1, MTSR_OFF_IRQ_MASK, 32'h3);
    foreach (rows[i])
    begin
      r = rows[i];
      apb(1, MTSR_OFF_CTRL, r.ctrl);
      nab = 0;
      nrt = 0;
      dma_in.underrun <= r.fu;
      dma_in.fragment_sum <= 16'(r.byte_count_mismatch_flag);
      fork
        med.send(r.ncoll, r.crs, r.late, 1'b0);
        begin
          repeat (30) @(posedge pclk);
          mon_in <= '{1'b1, r.al, 1'b0, 1'b0};
          @(posedge pclk);
          mon_in <= '0;
        end
      join
      for (k = 0; k < 2000 && desc_write_req !== 1'b1; k++) @(posedge pclk);
      dma_in.underrun <= 1'b0;
      @(posedge pclk);
      chk("status_word", r.exp, tx_descriptor_status_word & MASK);
      chk("aborts", r.nab, nab);
      chk("retries", r.nrt, nrt);
      apb(0, MTSR_OFF_DESC, 0);
      chk("desc_reg", r.exp, rd[15:0] & MASK);
      status_written <= 1'b1;
      @(posedge pclk);
      status_written <= 1'b0;
      apb(0, MTSR_OFF_TCR, 0);
      chk("late_cleared", 0, rd[5]);
    end
    // ----
    // deferral on first attempt, then cleared by a collision
    // ----
    apb(1, MTSR_OFF_CTRL, 0);
    for (int j = 0; j < 2; j++)
    begin
      med.send(j, 1'b1, 1'b0, 1'b1);
      for (k = 0; k < 2000 && desc_write_req !== 1'b1; k++) @(posedge pclk);
      @(posedge pclk);
      chk("deferred", 32'(j == 0), tx_descriptor_status_word[MTSR_B_DEF]);
      status_written <= 1'b1;
      @(posedge pclk);
      status_written <= 1'b0;
    end
    chk("irq_on", 1, irq);
    apb(1, MTSR_OFF_IRQ_MASK, 0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    apb(0, MTSR_OFF_IRQ_STAT, 0);
    chk("irq_done", 1, rd[0]);
    apb(1, MTSR_OFF_IRQ_STAT, 32'h3);
    apb(0, MTSR_OFF_IRQ_STAT, 0);
    chk("irq_cleared", 0, rd[1:0]);
    apb(0, 8'h40, 0);
    chk("slverr", 1, err);
    chk("unmapped_rd", 0, rd);
    // ----
    // reset in mid-run
    // ----
    presetn <= 1'b0;
    @(posedge pclk);
    chk("reset_word", 0, tx_descriptor_status_word);
    chk("reset_crc", 0, rx_crc_enable);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("crc_again", 1, rx_crc_enable);
    finish_test();
  end
endmodule // tb

// ===== design/mtsr_top.sv
// mac transmit status logic with apb registers
//
// Design decisions made here: register access over APB and the address map.
module mtsr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mtsr_pkg::mtsr_line_t line_in,
  input wire mtsr_pkg::mtsr_dma_t dma_in,
  input wire mtsr_pkg::mtsr_mon_t mon_in,
  input wire logic status_written,
  output logic tx_abort,
  output logic backoff_retry,
  output logic rx_crc_enable,
  output logic desc_write_req,
  output logic [15:0] tx_descriptor_status_word,
  output logic irq
);
  import mtsr_pkg::*;
  // ----------------------------------------
  // line input synchronisers
  // ----------------------------------------
  mtsr_line_t line_s1;
  mtsr_line_t line_s2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_s1 <= '0;
      line_s2 <= '0;
    end
    else
    begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
    end
  end
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  mtsr_state_t state;
  logic [15:0] transmit_control_and_status;
  logic [2:0] ctrl;
  logic [1:0] lb_mode;
  logic [10:0] slot_cnt;
  logic slot_run;
  logic slot_over;
  logic [4:0] coll_cnt;
  logic first_attempt;
  logic coll_prev;
  localparam int I_NUM_W = MTSR_I_NUM;
  logic [I_NUM_W-1:0] irq_stat;
  logic [I_NUM_W-1:0] irq_mask;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_tcr = paddr == MTSR_OFF_TCR;
  wire hit_ctrl = paddr == MTSR_OFF_CTRL;
  wire hit_desc = paddr == MTSR_OFF_DESC;
  wire hit_is = paddr == MTSR_OFF_IRQ_STAT;
  wire hit_im = paddr == MTSR_OFF_IRQ_MASK;
  wire hit_any = hit_tcr || hit_ctrl || hit_desc || hit_is || hit_im;
  wire fcs_inhibit = ctrl[MTSR_C_FCS_INH];
  wire late_collision_reference_select = ctrl[MTSR_C_LC_REF];
  wire sending = state == MTSR_SEND;
  wire coll = sending && line_s2.collision && !coll_prev;
  wire last_coll = coll && (coll_cnt == MTSR_MAX_COLL - 5'h01);
  wire size_bad = sending && dma_in.size_valid && (dma_in.packet_size != dma_in.fragment_sum);
  wire ufl = sending && dma_in.underrun;
  wire abort_now = last_coll || size_bad || ufl;
  wire finish = sending && (line_s2.done || abort_now);
  wire slot_start = late_collision_reference_select ? line_s2.sfd : line_s2.preamble_start;
  wire any_lb = lb_mode != MTSR_LB_NONE;
  wire mon_bad = mon_in.done && (mon_in.alignment_error || mon_in.address_miss) && !fcs_inhibit && !any_lb;
  wire err_any = transmit_control_and_status[MTSR_B_EXC] || transmit_control_and_status[MTSR_B_EXD] || transmit_control_and_status[MTSR_B_FU] || transmit_control_and_status[MTSR_B_BCM];
  wire [I_NUM_W-1:0] irq_ev = {finish && !(line_s2.done && !abort_now), finish};
  // ----------------------------------------
  // slot timer and collision count
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_cnt <= '0;
      slot_run <= 1'b0;
      slot_over <= 1'b0;
    end
    else if (!sending)
    begin
      slot_run <= 1'b0;
      slot_over <= 1'b0;
    end
    else if (slot_start && !slot_run)
    begin
      slot_cnt <= '0;
      slot_run <= 1'b1;
      slot_over <= 1'b0;
    end
    else if (slot_run && !slot_over)
    begin
      slot_cnt <= slot_cnt + 11'h001;
      slot_over <= slot_cnt >= MTSR_SLOT_CNT - 11'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coll_cnt <= '0;
      first_attempt <= 1'b0;
      coll_prev <= 1'b0;
      state <= MTSR_IDLE;
      backoff_retry <= 1'b0;
      tx_abort <= 1'b0;
      desc_write_req <= 1'b0;
    end
    else
    begin
      coll_prev <= line_s2.collision;
      backoff_retry <= coll && !last_coll;
      tx_abort <= abort_now;
      case (state)
        MTSR_IDLE:
        begin
          if (line_s2.preamble_start)
          begin
            state <= MTSR_SEND;
            coll_cnt <= '0;
            first_attempt <= 1'b1;
          end
        end
        MTSR_SEND:
        begin
          if (coll)
          begin
            coll_cnt <= coll_cnt + 5'h01;
            first_attempt <= 1'b0;
          end
          if (finish)
          begin
            state <= MTSR_WRITE;
            desc_write_req <= 1'b1;
          end
        end
        MTSR_WRITE:
        begin
          if (status_written)
          begin
            state <= MTSR_IDLE;
            desc_write_req <= 1'b0;
          end
        end
        default: state <= MTSR_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // transmit status bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transmit_control_and_status <= MTSR_ZERO16;
    else
    begin
      if (state == MTSR_IDLE && line_s2.preamble_start)
      begin
        transmit_control_and_status <= MTSR_ZERO16;
        transmit_control_and_status[MTSR_B_NO_CARRIER_FLAG] <= 1'b1;
        transmit_control_and_status[MTSR_B_CARRIER_LOST_FLAG] <= lb_mode == MTSR_LB_MAC;
      end
      if (sending)
      begin
        if (line_s2.carrier_sense && line_s2.sfd)
          transmit_control_and_status[MTSR_B_NO_CARRIER_FLAG] <= 1'b0;
        if (!line_s2.carrier_sense && (line_s2.sfd || (transmit_control_and_status[MTSR_B_NO_CARRIER_FLAG] && finish)))
          transmit_control_and_status[MTSR_B_CARRIER_LOST_FLAG] <= 1'b1;
        if (line_s2.deferred && first_attempt)
          transmit_control_and_status[MTSR_B_DEF] <= 1'b1;
        if (coll)
          transmit_control_and_status[MTSR_B_DEF] <= 1'b0;
        if (coll && slot_over)
          transmit_control_and_status[MTSR_B_OWC] <= 1'b1;
        if (last_coll)
        begin
          transmit_control_and_status[MTSR_B_EXC] <= 1'b1;
          transmit_control_and_status[MTSR_B_BCM] <= 1'b1;
        end
        if (size_bad)
          transmit_control_and_status[MTSR_B_BCM] <= 1'b1;
        if (ufl)
          transmit_control_and_status[MTSR_B_FU] <= 1'b1;
        if (dma_in.excessive_deferral)
          transmit_control_and_status[MTSR_B_EXD] <= 1'b1;
        if (line_s2.done && !abort_now && !err_any && !dma_in.excessive_deferral)
          transmit_control_and_status[MTSR_B_OK] <= 1'b1;
      end
      if (mon_bad)
        transmit_control_and_status[MTSR_B_PMB] <= 1'b1;
      if (state == MTSR_WRITE && status_written)
      begin
        transmit_control_and_status[MTSR_B_OWC] <= 1'b0;
        transmit_control_and_status[MTSR_B_DEF] <= 1'b0;
      end
    end
  end
  // descriptor word and crc enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_descriptor_status_word <= MTSR_ZERO16;
      rx_crc_enable <= 1'b0;
    end
    else
    begin
      rx_crc_enable <= 1'b1;
      if (state == MTSR_WRITE && !desc_write_req)
        tx_descriptor_status_word <= transmit_control_and_status;
      else if (desc_write_req && state == MTSR_WRITE)
        tx_descriptor_status_word <= transmit_control_and_status;
    end
  end
  // ----------------------------------------
  // apb slave and interrupts
  // ----------------------------------------
  wire [31:0] rd_mux = hit_tcr ? {16'h0000, transmit_control_and_status} :
                       hit_ctrl ? {27'h0, lb_mode, ctrl} :
                       hit_desc ? {16'h0000, tx_descriptor_status_word} :
                       hit_is ? {30'h0, irq_stat} :
                       hit_im ? {30'h0, irq_mask} : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0;
      lb_mode <= MTSR_LB_NONE;
      irq_stat <= '0;
      irq_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pready <= psel && !pready;
      pslverr <= psel && !pready && !hit_any;
      prdata <= rd_mux;
      if (wr && pready && hit_ctrl)
      begin
        ctrl <= pwdata[2:0];
        lb_mode <= pwdata[4:3];
      end
      if (wr && pready && hit_im)
        irq_mask <= pwdata[1:0];
      irq_stat <= (irq_stat & ~((wr && pready && hit_is) ? pwdata[1:0] : 2'h0)) | irq_ev;
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // mtsr_top

// ===== inc/mtsr_pkg.sv
// package of constants and types for the mac transmit status block
// Functional notes
// - no carrier seen sets both carrier flags
// - mac loopback always reports carrier lost
// - sixteenth collision aborts, sets bit 6
// - collision after slot time sets bit 5
// - slot measured from preamble or delimiter
// - late collision backs off, no abort
// - late collision bit cleared after status write
// - monitor alignment or address miss sets bit 3
// - receive crc checker runs during transmit
// - fcs inhibit holds monitored bad low
// - any loopback mode reports monitored bad zero
// - tx fifo underrun aborts, sets bit 2
// - size mismatch aborts, sets bit 1
// - excessive collisions also set mismatch bit
// - ok bit only without bits 1, 2, 6 or 10 (bits 3 and 5 may stand with it)
// - no carrier set at preamble, cleared on carrier
// - deferred set on deferral during first attempt, cleared on collision
package mtsr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] MTSR_OFF_TCR = 8'h00;
  localparam logic [7:0] MTSR_OFF_CTRL = 8'h04;
  localparam logic [7:0] MTSR_OFF_DESC = 8'h08;
  localparam logic [7:0] MTSR_OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] MTSR_OFF_IRQ_MASK = 8'h10;
  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int MTSR_B_OK = 0;
  localparam int MTSR_B_BCM = 1;
  localparam int MTSR_B_FU = 2;
  localparam int MTSR_B_PMB = 3;
  localparam int MTSR_B_OWC = 5;
  localparam int MTSR_B_EXC = 6;
  localparam int MTSR_B_CARRIER_LOST_FLAG = 7;
  localparam int MTSR_B_NO_CARRIER_FLAG = 8;
  localparam int MTSR_B_DEF = 9;
  localparam int MTSR_B_EXD = 10;
  // control bit positions
  localparam int MTSR_C_FCS_INH = 0;
  localparam int MTSR_C_LC_REF = 1;
  localparam int MTSR_C_LB_LO = 2;
  // interrupt bits
  localparam int MTSR_I_DONE = 0;
  localparam int MTSR_I_ERR = 1;
  localparam int MTSR_I_NUM = 2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MTSR_CLK_HZ = 20000000;
  localparam real MTSR_SLOT_US = 51.2;
  localparam int MTSR_SLOT_CYC = int'(MTSR_SLOT_US * real'(MTSR_CLK_HZ) / 1.0e6);
  localparam logic [10:0] MTSR_SLOT_CNT = 11'(MTSR_SLOT_CYC);
  localparam logic [4:0] MTSR_MAX_COLL = 5'h10;
  localparam logic [15:0] MTSR_ZERO16 = 16'h0000;
  // loopback modes
  localparam logic [1:0] MTSR_LB_NONE = 2'h0;
  localparam logic [1:0] MTSR_LB_MAC = 2'h1;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic preamble_start;
    logic sfd;
    logic carrier_sense;
    logic collision;
    logic deferred;
    logic done;
  } mtsr_line_t;
  typedef struct packed {
    logic underrun;
    logic excessive_deferral;
    logic [15:0] packet_size;
    logic [15:0] fragment_sum;
    logic size_valid;
  } mtsr_dma_t;
  typedef struct packed {
    logic done;
    logic alignment_error;
    logic address_miss;
    logic rx_fifo_overrun;
  } mtsr_mon_t;
  typedef enum logic [1:0] {MTSR_IDLE, MTSR_SEND, MTSR_WRITE} mtsr_state_t;
endpackage
